// ### uirq_pkg.sv
/*
  Constants for the per-channel interrupt mask and line state block of a
  dual UART: register addresses, field positions, reset values and the
  codes shown in the interrupt source register.
  Assumes the parallel register port and its three-bit register address.
*/
// Behaviour
// - mask bits 7-4 unused, read zero, never affect interrupts
// - mask bit 3 raises interrupt while any modem change flag is set
// - mask bit 2 raises interrupt while any receive error bit is set
// - character mode: mask bit 1 interrupts when tx holding register empties
// - fifo mode: tx interrupt only when tx fifo and holding register empty
// - source register shows rx data at level 2, tx empty at level 3
// - character mode: rx interrupt while rx holding register holds data
// - fifo mode: rx interrupt while fill is at or above trigger level
// - source register rx indication follows trigger level with the interrupt
// - line bit 0 set while rx fifo holds a byte, clear when empty
// - tx interrupt cleared by source register read or tx character write
// - all mask bits clear means no interrupts; host polls line state
// - line bit 5 shows the tx holding register empty, and in fifo mode also the tx fifo empty
// - line bit 6 set only when tx holding register and tx shift register empty, and in fifo mode also the tx fifo
// - line bit 7 shows a data error among characters in rx fifo
// - each channel has its own interrupt output pin
// - mask register sits at address 001 and resets to 00
`default_nettype none
package uirq_pkg;
  localparam int NUM_CHAN = 2;
  localparam int CHAN_A = 0;
  localparam int CHAN_B = 1;
  // register addresses in the general set
  localparam logic [2:0] ADDR_TX_RX = 3'h0;
  localparam logic [2:0] ADDR_MASK = 3'h1;
  localparam logic [2:0] ADDR_SOURCE = 3'h2;
  localparam logic [2:0] ADDR_LINE = 3'h5;
  // mask register fields and reset
  localparam int MASK_W = 4;
  localparam int MASK_RX = 0;
  localparam int MASK_TX = 1;
  localparam int MASK_LINE = 2;
  localparam int MASK_MODEM = 3;
  localparam logic [MASK_W-1:0] MASK_RESET = 4'h0;
  // source register codes, bits 3:0
  localparam logic [3:0] SRC_NONE = 4'h1;
  localparam logic [3:0] SRC_LINE = 4'h6;
  localparam logic [3:0] SRC_RX = 4'h4;
  localparam logic [3:0] SRC_TX = 4'h2;
  localparam logic [3:0] SRC_MODEM = 4'h0;
  // line state register fields
  localparam int LINE_RX_READY = 0;
  localparam int LINE_ERR_LO = 1;
  localparam int LINE_TX_EMPTY = 5;
  localparam int LINE_ALL_EMPTY = 6;
  localparam int LINE_FIFO_ERR = 7;
  localparam logic [7:0] RD_RESET = 8'h00;
endpackage
`default_nettype wire

// ### uirq_ctrl.sv
/*
  Interrupt mask, interrupt source and line state logic for both channels
  of a dual UART, behind the parallel register port.
  Assumes bus inputs synchronous to ref_clk, one access per strobe low
  phase, and that fifo counts, error and modem flags come from the
  channel datapaths in the same clock domain.
*/
`default_nettype none
module uirq_ctrl #(
  parameter int FIFO_DEPTH = 16,
  localparam int CW = $clog2(FIFO_DEPTH + 1)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // parallel register port
  input wire logic [2:0] addr,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic channelSelect,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  // per-channel state from the datapath, index 0 is channel A
  input wire logic fifoEnable [uirq_pkg::NUM_CHAN],
  input wire logic divisorLatchSel [uirq_pkg::NUM_CHAN],
  input wire logic [CW-1:0] rxCount [uirq_pkg::NUM_CHAN],
  input wire logic [CW-1:0] rxTrigLevel [uirq_pkg::NUM_CHAN],
  input wire logic [CW-1:0] txFifoCount [uirq_pkg::NUM_CHAN],
  input wire logic txHoldEmpty [uirq_pkg::NUM_CHAN],
  input wire logic txShiftEmpty [uirq_pkg::NUM_CHAN],
  input wire logic [3:0] rxErrFlags [uirq_pkg::NUM_CHAN],
  input wire logic rxFifoDataErr [uirq_pkg::NUM_CHAN],
  input wire logic [3:0] modemChange [uirq_pkg::NUM_CHAN],
  // interrupt pins
  output logic irqOutChanA,
  output logic irqOutChanB
);
  import uirq_pkg::*;

  // refused at elaboration: fill counts are sized for at most 255 entries
  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 255) begin : g_bad_depth
    $error("uirq_ctrl: FIFO_DEPTH out of range");
  end

  logic rdPrev_q;
  logic wrPrev_q;
  logic rdStart;
  logic wrStart;
  logic [7:0] rdData_q;
  logic [7:0] rdMux;
  logic [NUM_CHAN-1:0] irq_q;
  logic [NUM_CHAN-1:0] txPend_q;
  logic [NUM_CHAN-1:0] txCondPrev_q;
  logic [MASK_W-1:0] mask_q [NUM_CHAN];
  logic [7:0] lineState [NUM_CHAN];
  logic [7:0] sourceState [NUM_CHAN];
  logic [NUM_CHAN-1:0] chanHit;
  logic [NUM_CHAN-1:0] txCond;
  logic [NUM_CHAN-1:0] anyReq;
  logic [MASK_W-1:0] pend [NUM_CHAN];

  // strobes act once, on the first low cycle
  assign rdStart = !csN && !rdN && rdPrev_q;
  assign wrStart = !csN && !wrN && wrPrev_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPrev_q <= 1'h1;
      wrPrev_q <= 1'h1;
    end else begin
      rdPrev_q <= rdN;
      wrPrev_q <= wrN;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CHAN; c++) begin : g_chan
      // channel A is picked when select is high; divisor set hides the group
      assign chanHit[c] = (channelSelect == (c == CHAN_A)) && !divisorLatchSel[c];

      // character mode watches only the holding register
      assign txCond[c] = fifoEnable[c] ? (txHoldEmpty[c] && txFifoCount[c] == '0)
                                       : txHoldEmpty[c];

      always_comb begin
        pend[c] = '0;
        pend[c][MASK_RX] = fifoEnable[c] ? (rxCount[c] >= rxTrigLevel[c])
                                         : (rxCount[c] != '0);
        pend[c][MASK_TX] = txPend_q[c];
        pend[c][MASK_LINE] = |rxErrFlags[c];
        pend[c][MASK_MODEM] = |modemChange[c];
      end

      // upper mask bits never stored, so they cannot gate anything
      assign anyReq[c] = |(pend[c] & mask_q[c]);

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          mask_q[c] <= MASK_RESET;
        end else if (wrStart && chanHit[c] && addr == ADDR_MASK) begin
          mask_q[c] <= wrData[MASK_W-1:0];
        end
      end

      // tx empty is an event: latched on the empty edge, set beats clear
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          txCondPrev_q[c] <= 1'h1;
          txPend_q[c] <= 1'h0;
        end else begin
          txCondPrev_q[c] <= txCond[c];
          if (txCond[c] && !txCondPrev_q[c]) begin
            txPend_q[c] <= 1'h1;
          end else if (rdStart && chanHit[c] && addr == ADDR_SOURCE) begin
            txPend_q[c] <= 1'h0;
          end else if (wrStart && chanHit[c] && addr == ADDR_TX_RX) begin
            txPend_q[c] <= 1'h0;
          end
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_q[c] <= 1'h0;
        end else begin
          irq_q[c] <= anyReq[c];
        end
      end

      always_comb begin
        lineState[c] = '0;
        lineState[c][LINE_RX_READY] = rxCount[c] != '0;
        lineState[c][LINE_ERR_LO +: 4] = rxErrFlags[c];
        lineState[c][LINE_TX_EMPTY] = txCond[c];
        lineState[c][LINE_ALL_EMPTY] = txCond[c] && txShiftEmpty[c];
        lineState[c][LINE_FIFO_ERR] = fifoEnable[c] && rxFifoDataErr[c];
      end

      // highest enabled source wins: line, rx, tx, modem
      always_comb begin
        sourceState[c] = {fifoEnable[c], fifoEnable[c], 2'h0, SRC_NONE};
        if (pend[c][MASK_LINE] && mask_q[c][MASK_LINE]) begin
          sourceState[c][3:0] = SRC_LINE;
        end else if (pend[c][MASK_RX] && mask_q[c][MASK_RX]) begin
          sourceState[c][3:0] = SRC_RX;
        end else if (pend[c][MASK_TX] && mask_q[c][MASK_TX]) begin
          sourceState[c][3:0] = SRC_TX;
        end else if (pend[c][MASK_MODEM] && mask_q[c][MASK_MODEM]) begin
          sourceState[c][3:0] = SRC_MODEM;
        end
      end

      property p_modem_irq;
        @(posedge ref_clk) disable iff (!rst_n)
        (mask_q[c][MASK_MODEM] && |modemChange[c]) |=> irq_q[c];
      endproperty
      a_modem_irq: assert property (p_modem_irq)
        else $error("modem change enabled but no interrupt");

      property p_line_irq;
        @(posedge ref_clk) disable iff (!rst_n)
        (mask_q[c][MASK_LINE] && |rxErrFlags[c]) |=> irq_q[c];
      endproperty
      a_line_irq: assert property (p_line_irq)
        else $error("line error enabled but no interrupt");

      property p_tx_event;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(txPend_q[c]) |-> $past(txCond[c]) && !$past(txCondPrev_q[c]);
      endproperty
      a_tx_event: assert property (p_tx_event)
        else $error("tx pending set without empty edge");

      // a mask write in the same cycle legally withdraws the enable
      property p_tx_char;
        @(posedge ref_clk) disable iff (!rst_n)
        (!fifoEnable[c] && txHoldEmpty[c] && !txCondPrev_q[c] && mask_q[c][MASK_TX]
          && !(wrStart && chanHit[c] && addr == ADDR_MASK)) |-> ##2 irq_q[c];
      endproperty
      a_tx_char: assert property (p_tx_char)
        else $error("char mode tx empty did not interrupt");

      property p_tx_fifo;
        @(posedge ref_clk) disable iff (!rst_n)
        (fifoEnable[c] && txFifoCount[c] != '0) |=> !$rose(txPend_q[c]);
      endproperty
      a_tx_fifo: assert property (p_tx_fifo)
        else $error("tx event raised while tx fifo holds data");

      property p_rx_trig;
        @(posedge ref_clk) disable iff (!rst_n)
        (fifoEnable[c] && rxCount[c] < rxTrigLevel[c] && !(|mask_q[c][3:1]))
          |=> !irq_q[c];
      endproperty
      a_rx_trig: assert property (p_rx_trig)
        else $error("rx interrupt below trigger level");

      property p_rx_char;
        @(posedge ref_clk) disable iff (!rst_n)
        (!fifoEnable[c] && rxCount[c] != '0 && mask_q[c][MASK_RX]) |=> irq_q[c];
      endproperty
      a_rx_char: assert property (p_rx_char)
        else $error("rx data held but no interrupt");

      property p_src_rx;
        @(posedge ref_clk) disable iff (!rst_n)
        (fifoEnable[c] && rxCount[c] >= rxTrigLevel[c] && mask_q[c] == 4'h1)
          |-> sourceState[c][3:0] == SRC_RX;
      endproperty
      a_src_rx: assert property (p_src_rx)
        else $error("source register missing rx level 2");

      property p_line_bits;
        @(posedge ref_clk) disable iff (!rst_n)
        lineState[c][LINE_ALL_EMPTY] |-> txShiftEmpty[c] && txHoldEmpty[c]
          && lineState[c][LINE_RX_READY] == (rxCount[c] != '0);
      endproperty
      a_line_bits: assert property (p_line_bits)
        else $error("line state bits inconsistent");

      property p_line_tx;
        @(posedge ref_clk) disable iff (!rst_n)
        (fifoEnable[c] && txFifoCount[c] != '0) |-> !lineState[c][LINE_TX_EMPTY];
      endproperty
      a_line_tx: assert property (p_line_tx)
        else $error("tx empty bit set while tx fifo holds data");

      property p_fifo_err;
        @(posedge ref_clk) disable iff (!rst_n)
        (fifoEnable[c] && rxFifoDataErr[c]) |-> lineState[c][LINE_FIFO_ERR];
      endproperty
      a_fifo_err: assert property (p_fifo_err)
        else $error("fifo data error not shown in line state");

      property p_src_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        (rdStart && chanHit[c] && addr == ADDR_SOURCE && !(txCond[c] && !txCondPrev_q[c]))
          |=> !txPend_q[c];
      endproperty
      a_src_clear: assert property (p_src_clear)
        else $error("source read did not clear tx interrupt");

      property p_hidden_write;
        @(posedge ref_clk) disable iff (!rst_n)
        (wrStart && !chanHit[c]) |=> $stable(mask_q[c]);
      endproperty
      a_hidden_write: assert property (p_hidden_write)
        else $error("mask changed by a write that did not select it");

      property p_no_mask;
        @(posedge ref_clk) disable iff (!rst_n)
        (mask_q[c] == '0) [*2] |-> !irq_q[c];
      endproperty
      a_no_mask: assert property (p_no_mask)
        else $error("interrupt with all mask bits clear");

      property p_irq_eq;
        @(posedge ref_clk) disable iff (!rst_n)
        irq_q[c] == $past(anyReq[c]);
      endproperty
      a_irq_eq: assert property (p_irq_eq)
        else $error("interrupt pin not following enabled sources");

      c_irq_rise: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq_q[c]));
      c_tx_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
        txPend_q[c] ##1 !txPend_q[c]);
      c_mask_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
        wrStart && chanHit[c] && addr == ADDR_MASK);
      c_src_tx: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rdStart && chanHit[c] && addr == ADDR_SOURCE && sourceState[c][3:0] == SRC_TX);
    end
  endgenerate

  always_comb begin
    rdMux = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (chanHit[i]) begin
        unique case (addr)
          ADDR_MASK: rdMux = {{(8 - MASK_W){1'h0}}, mask_q[i]};
          ADDR_SOURCE: rdMux = sourceState[i];
          ADDR_LINE: rdMux = lineState[i];
          default: rdMux = '0;
        endcase
      end
    end
  end

  // data captured at strobe start so it stays still for the host
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= RD_RESET;
    end else if (rdStart) begin
      rdData_q <= rdMux;
    end
  end

  property p_mask_read;
    @(posedge ref_clk) disable iff (!rst_n)
    (rdStart && addr == ADDR_MASK) |=> rdData_q[7:4] == 4'h0;
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask upper bits read nonzero");

  assign rdData = rdData_q;
  assign irqOutChanA = irq_q[CHAN_A];
  assign irqOutChanB = irq_q[CHAN_B];
endmodule
`default_nettype wire

// ### uirq_host.sv
/*
  Host model for the parallel register port: one read or write per call.
  Assumes the bench clock; signals change 2 ns after a rising edge.
*/
`default_nettype none
module uirq_host (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [2:0] addr,
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic channelSelect,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {csN, rdN, wrN} = 3'h7;
    addr = 3'h0;
    channelSelect = 1'h1;
    wrData = 8'h00;
  end
  // strobe low for one taking edge, then high for at least one edge
  task automatic access(input bit rd, input logic [2:0] a, input bit chA,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk) #2;
    addr = a;
    channelSelect = chA;
    wrData = d;
    csN = 1'h0;
    rdN = !rd;
    wrN = rd;
    @(posedge ref_clk) #2;
    {csN, rdN, wrN} = 3'h7;
    // released bus must not look like held data
    wrData = ~d;
    @(posedge ref_clk) #2;
    q = rdData;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
/*
  Self-checking bench for the interrupt mask and line state block.
  Assumes uirq_pkg and uirq_ctrl; a host model drives the register port.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import uirq_pkg::*;
  localparam int CW = 5;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [2:0] addr;
  logic csN, rdN, wrN, channelSelect, irqOutChanA, irqOutChanB;
  logic [7:0] wrData, rdData, q;
  logic fifoEnable [NUM_CHAN], divisorLatchSel [NUM_CHAN], txHoldEmpty [NUM_CHAN];
  logic txShiftEmpty [NUM_CHAN], rxFifoDataErr [NUM_CHAN];
  logic [CW-1:0] rxCount [NUM_CHAN], rxTrigLevel [NUM_CHAN], txFifoCount [NUM_CHAN];
  logic [3:0] rxErrFlags [NUM_CHAN], modemChange [NUM_CHAN];
  int badCount = 0, checked = 0, seed = 59, c, rdPrev = 1, wrPrev = 1;
  int mask [NUM_CHAN], pend [NUM_CHAN], txPrev [NUM_CHAN];
  always #25 ref_clk = ~ref_clk;
  uirq_ctrl #(.FIFO_DEPTH(16)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
    .csN(csN), .rdN(rdN), .wrN(wrN), .channelSelect(channelSelect), .wrData(wrData),
    .rdData(rdData), .fifoEnable(fifoEnable), .divisorLatchSel(divisorLatchSel),
    .rxCount(rxCount), .rxTrigLevel(rxTrigLevel), .txFifoCount(txFifoCount),
    .txHoldEmpty(txHoldEmpty), .txShiftEmpty(txShiftEmpty), .rxErrFlags(rxErrFlags),
    .rxFifoDataErr(rxFifoDataErr), .modemChange(modemChange),
    .irqOutChanA(irqOutChanA), .irqOutChanB(irqOutChanB));
  uirq_host u_host (.ref_clk(ref_clk), .addr(addr), .csN(csN), .rdN(rdN), .wrN(wrN),
    .channelSelect(channelSelect), .wrData(wrData), .rdData(rdData));
  function automatic int txc(int k);
    return fifoEnable[k] ? int'(txHoldEmpty[k] && txFifoCount[k] == 0) : int'(txHoldEmpty[k]);
  endfunction
  function automatic int rxp(int k);
    return fifoEnable[k] ? int'(rxCount[k] >= rxTrigLevel[k]) : int'(rxCount[k] != 0);
  endfunction
  function automatic logic [7:0] expLine(int k);
    int t = txc(k);
    return 8'((rxCount[k] != 0) | (int'(rxErrFlags[k]) << 1) | (t << 5)
      | ((t & txShiftEmpty[k]) << 6) | ((fifoEnable[k] & rxFifoDataErr[k]) << 7));
  endfunction
  function automatic logic [7:0] expSrc(int k);
    int code = 1;
    if (mask[k][3] && modemChange[k] != 0) code = 0;
    if (mask[k][1] && pend[k] != 0) code = 2;
    if (mask[k][0] && rxp(k) != 0) code = 4;
    if (mask[k][2] && rxErrFlags[k] != 0) code = 6;
    return 8'((fifoEnable[k] ? 8'hc0 : 8'h00) | code);
  endfunction
  // tx source is an edge event, cleared by source read or tx char write
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend = '{0, 0};
      txPrev = '{1, 1};
    end else begin
      for (int k = 0; k < NUM_CHAN; k++) begin
        if (!csN && !divisorLatchSel[k] && channelSelect == (k == 0) &&
            ((!rdN && rdPrev && addr == ADDR_SOURCE) || (!wrN && wrPrev && addr == ADDR_TX_RX)))
          pend[k] = 0;
        if (txc(k) != 0 && txPrev[k] == 0) pend[k] = 1;
        txPrev[k] = txc(k);
      end
      rdPrev = rdN;
      wrPrev = wrN;
    end
  end
  task automatic chkReg(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkIrq(string nm, logic e, logic g);
    checked++;
    if (g !== e) begin
      badCount++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkPins();
    chkIrq("irqOutChanA", (expSrc(0) & 8'h0f) != 8'h01, irqOutChanA);
    chkIrq("irqOutChanB", (expSrc(1) & 8'h0f) != 8'h01, irqOutChanB);
  endtask
  task automatic rd(int k, logic [2:0] a, string nm, logic [7:0] e);
    u_host.access(1'h1, a, k == 0, 8'h00, q);
    chkReg(nm, e, q);
  endtask
  task automatic wr(int k, logic [2:0] a, logic [7:0] d);
    u_host.access(1'h0, a, k == 0, d, q);
    if (a == ADDR_MASK && !divisorLatchSel[k]) mask[k] = int'(d[3:0]);
  endtask
  // sparse error and modem flags so lower priority codes still show
  task automatic setInputs();
    for (int k = 0; k < NUM_CHAN; k++) begin
      fifoEnable[k] = 1'($random(seed));
      rxCount[k] = fifoEnable[k] ? 5'({$random(seed)} % 17) : 5'({$random(seed)} % 2);
      rxTrigLevel[k] = 5'(1 + {$random(seed)} % 16);
      txFifoCount[k] = fifoEnable[k] ? 5'({$random(seed)} % 3) : 5'h00;
      txHoldEmpty[k] = 1'($random(seed));
      txShiftEmpty[k] = 1'($random(seed));
      rxErrFlags[k] = 4'($random(seed) & $random(seed) & $random(seed));
      modemChange[k] = 4'($random(seed) & $random(seed) & $random(seed));
      rxFifoDataErr[k] = 1'($random(seed));
    end
  endtask
  task automatic endSim();
    if (badCount == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk);
    badCount++;
    endSim();
  end
  initial begin
    mask = '{0, 0};
    divisorLatchSel = '{1'h0, 1'h0};
    setInputs();
    repeat (16) @(posedge ref_clk);
    #2 rst_n = 1'h1;
    for (int k = 0; k < NUM_CHAN; k++) begin
      rd(k, ADDR_MASK, "mask", 8'h00);
      wr(k, ADDR_MASK, 8'hff);
      rd(k, ADDR_MASK, "mask", 8'h0f);
      rd(k, 3'h7, "unmapped", 8'h00);
      divisorLatchSel[k] = 1'h1;
      rd(k, ADDR_MASK, "hiddenMask", 8'h00);
      wr(k, ADDR_MASK, 8'h00);
      divisorLatchSel[k] = 1'h0;
      rd(k, ADDR_MASK, "keptMask", 8'h0f);
    end
    repeat (300) begin
      @(posedge ref_clk) #2;
      setInputs();
      c = {$random(seed)} % 2;
      wr(c, ADDR_MASK, 8'($random(seed)));
      rd(c, ADDR_MASK, "mask", 8'(mask[c]));
      rd(1 - c, ADDR_MASK, "otherMask", 8'(mask[1 - c]));
      if ({$random(seed)} % 4 == 0) wr(c, ADDR_TX_RX, 8'h55);
      repeat (2) @(posedge ref_clk);
      #2 chkPins();
      for (int k = 0; k < NUM_CHAN; k++) begin
        rd(k, ADDR_LINE, "line", expLine(k));
        rd(k, ADDR_SOURCE, "source", expSrc(k));
      end
      repeat (2) @(posedge ref_clk);
      #2 chkPins();
    end
    endSim();
  end
endmodule
`default_nettype wire
